// ### isa_switch_pkg.sv
// constants for the option switch decoder
package isa_switch_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int IO_W = 16;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'hC;
  localparam logic [IO_W-1:0] IO_BASE_FIRST = 16'h02A0;
  localparam int IO_STEP_SHIFT = 10;
  localparam int IO_WINDOW_DEF = 16;
  // factory switch positions, 1 = on, and the card and irq level they decode to
  localparam logic WIDTH_SW_DEF = 1'h1;
  localparam logic KIND_SW_DEF = 1'h1;
  localparam logic [3:0] BASE_SW_DEF = 4'hF;
  localparam logic [2:0] IRQ_SW_DEF = 3'h3;
  localparam logic [3:0] CARD_DEF = 4'h0;
  localparam logic [3:0] IRQ_LEVEL_DEF = 4'hA;
  // interrupt levels by code
  localparam logic [3:0] IRQ_L0 = 4'h3;
  localparam logic [3:0] IRQ_L1 = 4'h4;
  localparam logic [3:0] IRQ_L2 = 4'h7;
  localparam logic [3:0] IRQ_L3 = 4'h9;
  localparam logic [3:0] IRQ_L4 = 4'hA;
  localparam logic [3:0] IRQ_L5 = 4'hB;
  localparam logic [3:0] IRQ_L6 = 4'hC;
  localparam logic [3:0] IRQ_L7 = 4'hF;
  // status, config and control field positions
  localparam int ST_CFG_CHANGE = 0;
  localparam int ST_IO_READ = 1;
  localparam int ST_IO_WRITE = 2;
  localparam int ST_W = 3;
  localparam int CF_WIDE = 0;
  localparam int CF_DOUBLE = 1;
  localparam int CF_PCI = 2;
  localparam int CF_CARD_LO = 4;
  localparam int CF_IRQ_LO = 8;
  localparam int CF_BASE_LO = 16;
  localparam int CT_HOST_IRQ = 0;
endpackage : isa_switch_pkg

// ### isa_option_switch_decode.sv
// option switch decoder with isa window, host irq and avalon registers
`timescale 1ns/1ps
module isa_option_switch_decode #(
  parameter int IO_WINDOW = isa_switch_pkg::IO_WINDOW_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pci_mode,
  input wire logic data_width_switch,
  input wire logic connector_kind_switch,
  input wire logic io_base_sel_bit3,
  input wire logic io_base_sel_bit2,
  input wire logic io_base_sel_bit1,
  input wire logic io_base_sel_bit0,
  input wire logic irq_sel_bit2,
  input wire logic irq_sel_bit1,
  input wire logic irq_sel_bit0,
  input wire logic [isa_switch_pkg::IO_W-1:0] isa_addr,
  input wire logic isa_ior_n,
  input wire logic isa_iow_n,
  input wire logic [isa_switch_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [isa_switch_pkg::DATA_W-1:0] avs_writedata,
  output logic [isa_switch_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic data_16bit,
  output logic double_edge,
  output logic [isa_switch_pkg::IO_W-1:0] io_base,
  output logic [3:0] card_id,
  output logic [3:0] irq_level,
  output logic io_hit,
  output logic [15:0] isa_irq_o,
  output logic [15:0] isa_irq_oe
);

  // irq level per switch code
  function automatic logic [3:0] irq_of(input logic [2:0] code);
    logic [3:0] lvl;
    lvl = isa_switch_pkg::IRQ_L0;
    case (code)
      3'h0: lvl = isa_switch_pkg::IRQ_L0;
      3'h1: lvl = isa_switch_pkg::IRQ_L1;
      3'h2: lvl = isa_switch_pkg::IRQ_L2;
      3'h3: lvl = isa_switch_pkg::IRQ_L3;
      3'h4: lvl = isa_switch_pkg::IRQ_L4;
      3'h5: lvl = isa_switch_pkg::IRQ_L5;
      3'h6: lvl = isa_switch_pkg::IRQ_L6;
      default: lvl = isa_switch_pkg::IRQ_L7;
    endcase
    return lvl;
  endfunction : irq_of

  // base i/o address per switch code
  function automatic logic [isa_switch_pkg::IO_W-1:0] base_of(
    input logic [3:0] code);
    return isa_switch_pkg::IO_BASE_FIRST +
      (isa_switch_pkg::IO_W'(code) << isa_switch_pkg::IO_STEP_SHIFT);
  endfunction : base_of

  // switch sampling
  logic width_sw_reg;
  logic kind_sw_reg;
  logic [3:0] base_sw_reg;
  logic [2:0] irq_sw_reg;
  logic [9:0] sw_all;
  logic [9:0] sw_all_prev;
  logic cfg_change;

  // decoded configuration
  logic data_16bit_reg;
  logic double_edge_reg;
  logic [isa_switch_pkg::IO_W-1:0] io_base_reg;
  logic [3:0] card_id_reg;
  logic [3:0] irq_level_reg;
  logic [3:0] base_code;
  logic [2:0] irq_code;
  logic [isa_switch_pkg::IO_W-1:0] base_next;

  // host cycle decode
  logic [isa_switch_pkg::IO_W:0] addr_off;
  logic in_window;
  logic rd_hit;
  logic wr_hit;
  logic rd_hit_reg;
  logic wr_hit_reg;
  logic io_hit_reg;

  // host interrupt drive
  logic [15:0] level_onehot;
  logic [15:0] isa_irq_o_reg;
  logic [15:0] isa_irq_oe_reg;
  logic [15:0] isa_irq_oe_next;

  // register file
  logic host_irq_reg;
  logic [isa_switch_pkg::ST_W-1:0] status_reg;
  logic [isa_switch_pkg::ST_W-1:0] status_next;
  logic [isa_switch_pkg::ST_W-1:0] mask_reg;
  logic [isa_switch_pkg::ST_W-1:0] events;
  logic irq_reg;
  logic wait_reg;
  logic wait_next;
  logic accept;
  logic wr_acc;
  logic rd_acc;
  logic [isa_switch_pkg::DATA_W-1:0] rdata_reg;
  logic [isa_switch_pkg::DATA_W-1:0] rdata_next;
  logic [isa_switch_pkg::DATA_W-1:0] config_word;
  logic sel_config;
  logic sel_ctrl;
  logic sel_status;
  logic sel_mask;
  logic wr_mask;
  logic wr_ctrl;
  logic rd_status;
  logic [isa_switch_pkg::ST_W-1:0] clr_bits;
  logic irq_next;
  logic rd_rise;
  logic wr_rise;
  logic cfg_event;

  // switch image at the factory positions, 1 = on
  localparam logic [9:0] SW_FACTORY = {isa_switch_pkg::WIDTH_SW_DEF,
    isa_switch_pkg::KIND_SW_DEF, isa_switch_pkg::BASE_SW_DEF, 1'b0,
    isa_switch_pkg::IRQ_SW_DEF};

  // switch sampling, held while in a pci slot
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      width_sw_reg <= isa_switch_pkg::WIDTH_SW_DEF;
      kind_sw_reg <= isa_switch_pkg::KIND_SW_DEF;
      base_sw_reg <= isa_switch_pkg::BASE_SW_DEF;
      irq_sw_reg <= isa_switch_pkg::IRQ_SW_DEF;
    end else if (!pci_mode) begin
      width_sw_reg <= data_width_switch;
      kind_sw_reg <= connector_kind_switch;
      base_sw_reg <= {io_base_sel_bit3, io_base_sel_bit2,
                      io_base_sel_bit1, io_base_sel_bit0};
      irq_sw_reg <= {irq_sel_bit2, irq_sel_bit1, irq_sel_bit0};
    end
  end

  // on counts as zero, off as one
  assign base_code = ~base_sw_reg;
  assign irq_code = ~irq_sw_reg;
  assign base_next = base_of(base_code);
  assign sw_all = {width_sw_reg, kind_sw_reg, base_sw_reg,
                   1'b0, irq_sw_reg};

  // decoded configuration, factory values from reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      data_16bit_reg <= ~isa_switch_pkg::WIDTH_SW_DEF;
      double_edge_reg <= isa_switch_pkg::KIND_SW_DEF;
      io_base_reg <= isa_switch_pkg::IO_BASE_FIRST;
      card_id_reg <= isa_switch_pkg::CARD_DEF;
      irq_level_reg <= isa_switch_pkg::IRQ_LEVEL_DEF;
    end else begin
      data_16bit_reg <= ~width_sw_reg;
      double_edge_reg <= kind_sw_reg;
      io_base_reg <= base_next;
      card_id_reg <= base_code;
      irq_level_reg <= irq_of(irq_code);
    end
  end

  // previous switch image, for change detection
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sw_all_prev <= SW_FACTORY;
    end else begin
      sw_all_prev <= sw_all;
    end
  end

  assign cfg_change = sw_all != sw_all_prev;

  // host cycle window decode
  assign addr_off = {1'b0, isa_addr} - {1'b0, io_base_reg};
  assign in_window = !addr_off[isa_switch_pkg::IO_W] &&
    (addr_off < (isa_switch_pkg::IO_W + 1)'(IO_WINDOW));
  assign rd_hit = !pci_mode && in_window && !isa_ior_n;
  assign wr_hit = !pci_mode && in_window && !isa_iow_n;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_hit_reg <= 1'b0;
      wr_hit_reg <= 1'b0;
      io_hit_reg <= 1'b0;
    end else begin
      rd_hit_reg <= rd_hit;
      wr_hit_reg <= wr_hit;
      io_hit_reg <= rd_hit || wr_hit;
    end
  end

  // host interrupt: only the selected line, driven only while raised
  assign level_onehot = 16'h0001 << irq_level_reg;
  assign isa_irq_oe_next = (host_irq_reg && !pci_mode) ?
    level_onehot : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      isa_irq_o_reg <= 16'h0000;
      isa_irq_oe_reg <= 16'h0000;
    end else begin
      isa_irq_o_reg <= isa_irq_oe_next;
      isa_irq_oe_reg <= isa_irq_oe_next;
    end
  end

  // avalon slave: one wait cycle, then accept
  assign wait_next = !((avs_read || avs_write) && wait_reg);
  assign accept = !wait_reg;
  assign wr_acc = accept && avs_write;
  assign rd_acc = accept && avs_read;
  assign sel_config = avs_address == isa_switch_pkg::CONFIG_OFS;
  assign sel_ctrl = avs_address == isa_switch_pkg::CTRL_OFS;
  assign sel_status = avs_address == isa_switch_pkg::STATUS_OFS;
  assign sel_mask = avs_address == isa_switch_pkg::MASK_OFS;
  assign wr_mask = wr_acc && sel_mask;
  assign wr_ctrl = wr_acc && sel_ctrl;
  assign rd_status = rd_acc && sel_status;

  assign config_word = {
    io_base_reg,
    4'h0, irq_level_reg,
    card_id_reg,
    1'b0, pci_mode, double_edge_reg, data_16bit_reg};

  assign rdata_next =
    sel_config ? config_word :
    sel_ctrl ? isa_switch_pkg::DATA_W'(host_irq_reg) :
    sel_status ? isa_switch_pkg::DATA_W'(status_reg) :
    sel_mask ? isa_switch_pkg::DATA_W'(mask_reg) :
    '0;

  // one event per strobe edge; a new event wins over the read clear
  assign rd_rise = rd_hit && !rd_hit_reg;
  assign wr_rise = wr_hit && !wr_hit_reg;
  assign cfg_event = cfg_change && !pci_mode;
  assign events = {wr_rise, rd_rise, cfg_event};
  // clear only what the read reported, so a later event is not lost
  assign clr_bits = rd_status ? rdata_reg[isa_switch_pkg::ST_W-1:0] : '0;
  assign status_next = (status_reg & ~clr_bits) | events;
  assign irq_next = |(status_next & mask_reg);

  // bus handshake: one wait cycle per request
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= wait_next;
    end
  end

  // read data loads while waiting and stands through the accept
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_reg <= '0;
    end else if (wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // sticky status and the level interrupt
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  // mask, written when the bus accepts
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mask_reg <= '0;
    end else if (wr_mask) begin
      mask_reg <= avs_writedata[isa_switch_pkg::ST_W-1:0];
    end
  end

  // host interrupt request bit
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      host_irq_reg <= 1'b0;
    end else if (wr_ctrl) begin
      host_irq_reg <= avs_writedata[isa_switch_pkg::CT_HOST_IRQ];
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq = irq_reg;
  assign data_16bit = data_16bit_reg;
  assign double_edge = double_edge_reg;
  assign io_base = io_base_reg;
  assign card_id = card_id_reg;
  assign irq_level = irq_level_reg;
  assign io_hit = io_hit_reg;
  assign isa_irq_o = isa_irq_o_reg;
  assign isa_irq_oe = isa_irq_oe_reg;

endmodule : isa_option_switch_decode

// ### isa_switch_checker.sv
// port checker for the option switch decoder
`timescale 1ns/1ps
module isa_switch_checker #(
  parameter int IO_WINDOW = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pci_mode,
  input wire logic data_width_switch,
  input wire logic connector_kind_switch,
  input wire logic io_base_sel_bit3,
  input wire logic io_base_sel_bit2,
  input wire logic io_base_sel_bit1,
  input wire logic io_base_sel_bit0,
  input wire logic irq_sel_bit2,
  input wire logic irq_sel_bit1,
  input wire logic irq_sel_bit0,
  input wire logic [15:0] isa_addr,
  input wire logic isa_ior_n,
  input wire logic isa_iow_n,
  input wire logic data_16bit,
  input wire logic double_edge,
  input wire logic [15:0] io_base,
  input wire logic [3:0] card_id,
  input wire logic [3:0] irq_level,
  input wire logic io_hit,
  input wire logic [15:0] isa_irq_o,
  input wire logic [15:0] isa_irq_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [3:0] code_w;
  logic [2:0] lvc_w;
  logic [3:0] lvl_w;
  assign code_w = ~{io_base_sel_bit3, io_base_sel_bit2, io_base_sel_bit1,
    io_base_sel_bit0};
  assign lvc_w = ~{irq_sel_bit2, irq_sel_bit1, irq_sel_bit0};
  assign lvl_w = 4'(32'hFCBA9743 >> {lvc_w, 2'b00});
  sequence live;
    $past(reset_n) && $past(reset_n, 2) && !$past(pci_mode, 2);
  endsequence
  AST_WIDTH: assert property (
    live |-> data_16bit == !$past(data_width_switch, 2))
    else $error("width");
  AST_KIND: assert property (
    live |-> double_edge == $past(connector_kind_switch, 2))
    else $error("connector");
  AST_BASE: assert property (
    live |-> io_base == 16'h02A0 + {2'h0, $past(code_w, 2), 10'h000})
    else $error("base");
  AST_CARD: assert property (
    live |-> card_id == $past(code_w, 2))
    else $error("card");
  AST_LEVEL: assert property (
    live |-> irq_level == $past(lvl_w, 2))
    else $error("level");
  AST_PCI: assert property (
    pci_mode [*2] |-> !io_hit && isa_irq_oe == 16'h0000)
    else $error("pci");
  AST_SHARE: assert property (
    isa_irq_o == isa_irq_oe && $onehot0(isa_irq_oe))
    else $error("share");
  AST_LINE: assert property (
    isa_irq_oe != 16'h0000 && $stable(irq_level) |->
    isa_irq_oe == 16'h0001 << irq_level)
    else $error("line");
  AST_HIT: assert property (
    $past(reset_n) |-> io_hit == $past(!pci_mode &&
    !(isa_ior_n && isa_iow_n) && isa_addr >= io_base &&
    isa_addr < io_base + IO_WINDOW))
    else $error("hit");
  cover property (io_hit);
  cover property (isa_irq_oe != 16'h0000);
  cover property (pci_mode && isa_irq_oe == 16'h0000);
endmodule : isa_switch_checker
bind isa_option_switch_decode isa_switch_checker #(.IO_WINDOW(IO_WINDOW))
  isa_switch_checker_i (.*);

// ### isa_host_model.sv
// host bus model issuing i/o read and write cycles
`timescale 1ns/1ps
module isa_host_model (
  input wire logic clk_sys,
  output logic [15:0] isa_addr,
  output logic isa_ior_n,
  output logic isa_iow_n
);
  initial begin
    isa_addr = 16'h0000;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
  end
  // released address shows the inverse of the last one
  task automatic cycle(input logic [15:0] a, input logic rd);
    @(posedge clk_sys);
    isa_addr <= a;
    isa_ior_n <= !rd;
    isa_iow_n <= rd;
    repeat (3) @(posedge clk_sys);
    isa_ior_n <= 1'b1;
    isa_iow_n <= 1'b1;
    isa_addr <= ~a;
  endtask : cycle
endmodule : isa_host_model

// ### tb_isa_option_switch_decode.sv
// testbench for the option switch decoder
`timescale 1ns/1ps
module tb_isa_option_switch_decode;
  localparam int IO_WINDOW = 16;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic pci_mode = 1'b0;
  logic [9:0] sw = 10'h3F3;
  logic [9:0] old;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q, r;
  logic avs_waitrequest, irq, data_16bit, double_edge, io_hit;
  logic isa_ior_n, isa_iow_n;
  logic [15:0] io_base, isa_addr, isa_irq_o, isa_irq_oe;
  logic [3:0] card_id, irq_level;
  int ofs [4] = '{-1, 0, IO_WINDOW - 1, IO_WINDOW};
  integer seed = 32'he4c4777a;
  int bad_count = 0;
  int cmp_count = 0;
  always #2 clk_sys = ~clk_sys;
  isa_host_model isa_host_model_i (.*);
  isa_option_switch_decode #(.IO_WINDOW(IO_WINDOW))
    isa_option_switch_decode_i (.*, .data_width_switch(sw[9]),
    .connector_kind_switch(sw[8]), .io_base_sel_bit3(sw[7]),
    .io_base_sel_bit2(sw[6]), .io_base_sel_bit1(sw[5]),
    .io_base_sel_bit0(sw[4]), .irq_sel_bit2(sw[2]),
    .irq_sel_bit1(sw[1]), .irq_sel_bit0(sw[0]));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] s, logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  function automatic logic [31:0] exp_cfg(input logic [9:0] s, logic p);
    logic [3:0] c;
    c = ~s[7:4];
    exp_cfg = {16'h02A0 + {2'h0, c, 10'h000}, 4'h0,
      4'(32'hFCBA9743 >> {~s[2:0], 2'b00}), c, 1'b0, p, s[8], !s[9]};
  endfunction : exp_cfg
  task automatic setsw(input logic [9:0] v);
    @(posedge clk_sys);
    sw <= v;
    repeat (5) @(posedge clk_sys);
  endtask : setsw
  task automatic cfg(input logic [9:0] s);
    r = exp_cfg(s, pci_mode);
    chk("ports", {io_base, 4'h0, irq_level, card_id, 1'b0, pci_mode,
      double_edge, data_16bit}, r);
    bus(1'b0, 4'h0, 32'h0);
    chk("config", q, r);
  endtask : cfg
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("factory", {io_base, 4'h0, irq_level, card_id, 1'b0, pci_mode,
      double_edge, data_16bit}, 32'h02A00A02);
    cfg(sw);
    bus(1'b1, 4'hC, 32'h1);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      setsw({r[1:0], ~i[3:0], r[2], ~i[2:0]});
      chk("irq", irq, 32'h1);
      bus(1'b0, 4'h8, 32'h0);
      chk("status", q, 32'h1);
      cfg(sw);
      chk("irq clear", irq, 32'h0);
    end
    $display("test decode done");
    for (int j = 0; j < 4; j++) begin
      isa_host_model_i.cycle(16'(io_base + ofs[j]), j[0]);
      chk("io hit pin", io_hit, (j == 1 || j == 2) ? 32'h1 : 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      chk("io hit", q, (j == 1) ? 32'h2 : (j == 2) ? 32'h4 : 32'h0);
    end
    bus(1'b1, 4'h4, 32'h1);
    repeat (2) @(posedge clk_sys);
    r = exp_cfg(sw, 1'b0);
    chk("irq drive", isa_irq_oe, 32'h1 << r[11:8]);
    chk("irq value", isa_irq_o, 32'h1 << r[11:8]);
    old = sw;
    pci_mode <= 1'b1;
    setsw(~sw);
    chk("pci irq", isa_irq_oe, 32'h0);
    cfg(old);
    isa_host_model_i.cycle(io_base, 1'b1);
    chk("pci hit", io_hit, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk("pci io", q, 32'h0);
    pci_mode <= 1'b0;
    bus(1'b1, 4'hC, 32'h0);
    bus(1'b1, 4'h4, 32'h0);
    setsw(sw ^ 10'h010);
    chk("masked irq", irq, 32'h0);
    chk("irq off", isa_irq_oe, 32'h0);
    cfg(sw);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test host done");
    report_and_stop();
  end
endmodule : tb_isa_option_switch_decode
